// ### verilog/tcpq_map.svh
// Widths, counts and reset values of the quad timer/counter/PWM unit
`ifndef TCPQ_MAP_SVH
`define TCPQ_MAP_SVH

`define TCPQ_NUM_CH 4
`define TCPQ_CNT_W 16
`define TCPQ_DB_W 8
`define TCPQ_DIV_W 16
`define TCPQ_CNT_RST 16'h0000
`define TCPQ_CAP_RST 16'h0000
`define TCPQ_DB_RST 8'h00
`define TCPQ_DIV_RST 16'h0000
`define TCPQ_CNT_STEP 16'h0001
`define TCPQ_DB_STEP 8'h01
`define TCPQ_DIV_STEP 16'h0001

`endif

// ### verilog/tcpq_pkg.sv
// Types shared by the quad timer/counter/PWM unit
package tcpq_pkg;

   typedef enum logic {
      TCPQ_ONESHOT = 1'b0,
      TCPQ_RELOAD = 1'b1
   } tcpq_period_mode_t;

   typedef enum logic [1:0] {
      TCPQ_DB_SETTLED = 2'b00,
      TCPQ_DB_WAIT = 2'b01
   } tcpq_db_state_t;

endpackage : tcpq_pkg

// ### verilog/tcpq_channel.sv
// One 16-bit counter with period match, capture and compare
`timescale 1ns/1ps
`include "tcpq_map.svh"

module tcpq_channel
   import tcpq_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Control
   input wire logic tick,
   input wire logic enable,
   input wire logic reload_mode,
   input wire logic [`TCPQ_CNT_W-1:0] period,
   input wire logic [`TCPQ_CNT_W-1:0] compare,
   input wire logic cap_pulse,
   // Status
   output logic [`TCPQ_CNT_W-1:0] count_q,
   output logic [`TCPQ_CNT_W-1:0] cap_q,
   output logic pwm_q,
   output logic tc_q,
   output logic run_q
);

   tcpq_period_mode_t mode;
   logic halted_q;
   logic match;
   logic advance;
   logic [`TCPQ_CNT_W-1:0] count_d;

   assign mode = tcpq_period_mode_t'(reload_mode);
   assign match = (count_q == period);
   assign advance = enable && !halted_q && tick;
   // On a match the counter either wraps to zero or parks on the period value
   assign count_d = !enable ? `TCPQ_CNT_RST :
                    !advance ? count_q :
                    match ? ((mode == TCPQ_RELOAD) ? `TCPQ_CNT_RST : count_q) :
                    count_q + `TCPQ_CNT_STEP;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         count_q <= `TCPQ_CNT_RST;
         halted_q <= 1'b0;
         tc_q <= 1'b0;
      end else begin
         count_q <= count_d;
         halted_q <= enable && (halted_q || (advance && match && mode == TCPQ_ONESHOT));
         tc_q <= advance && match;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cap_q <= `TCPQ_CAP_RST;
         pwm_q <= 1'b0;
         run_q <= 1'b0;
      end else begin
         if (cap_pulse) begin
            cap_q <= count_q;
         end
         pwm_q <= enable && (count_q < compare);
         run_q <= enable && !halted_q;
      end
   end

endmodule : tcpq_channel

// ### verilog/tcpq_top.sv
// Quad 16-bit timer/counter/PWM with dead band and kill
`timescale 1ns/1ps
`include "tcpq_map.svh"

module tcpq_top
   import tcpq_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Shared clock divider, enable every clk_div+1 cycles
   input wire logic [`TCPQ_DIV_W-1:0] clk_div,
   // Per-counter configuration
   input wire logic [`TCPQ_NUM_CH-1:0] cnt_enable,
   input wire logic [`TCPQ_NUM_CH-1:0] cnt_reload,
   input wire logic [`TCPQ_NUM_CH-1:0][`TCPQ_CNT_W-1:0] cnt_period,
   input wire logic [`TCPQ_NUM_CH-1:0][`TCPQ_CNT_W-1:0] cnt_compare,
   input wire logic [`TCPQ_NUM_CH-1:0][`TCPQ_DB_W-1:0] dead_time,
   // Capture event inputs, rising edge
   input wire logic [`TCPQ_NUM_CH-1:0] cap_event,
   // Kill
   input wire logic kill,
   input wire logic kill_latch,
   input wire logic kill_clear,
   input wire logic [`TCPQ_NUM_CH-1:0] kill_true_lvl,
   input wire logic [`TCPQ_NUM_CH-1:0] kill_comp_lvl,
   // PWM pins
   output logic [`TCPQ_NUM_CH-1:0] pwm_true_q,
   output logic [`TCPQ_NUM_CH-1:0] pwm_comp_q,
   // Status
   output logic [`TCPQ_NUM_CH-1:0][`TCPQ_CNT_W-1:0] count_q,
   output logic [`TCPQ_NUM_CH-1:0][`TCPQ_CNT_W-1:0] capture_q,
   output logic [`TCPQ_NUM_CH-1:0] cap_done_q,
   output logic [`TCPQ_NUM_CH-1:0] period_match_q,
   output logic [`TCPQ_NUM_CH-1:0] running_q,
   output logic kill_active_q
);

   // Divided clock enable
   logic [`TCPQ_DIV_W-1:0] div_cnt_q;
   logic [`TCPQ_DIV_W-1:0] div_cnt_d;
   logic div_wrap;
   logic tick_q;

   // Greater-or-equal so that lowering clk_div mid-count cannot strand the divider
   assign div_wrap = (div_cnt_q >= clk_div);
   assign div_cnt_d = div_wrap ? `TCPQ_DIV_RST : div_cnt_q + `TCPQ_DIV_STEP;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         div_cnt_q <= `TCPQ_DIV_RST;
         tick_q <= 1'b0;
      end else begin
         div_cnt_q <= div_cnt_d;
         tick_q <= div_wrap;
      end
   end

   // Capture edge detect; pins are taken as synchronous to mclk
   logic [`TCPQ_NUM_CH-1:0] cap_prev_q;
   logic [`TCPQ_NUM_CH-1:0] cap_pulse;

   // Only a rising edge captures, so a held level cannot keep overwriting the count
   assign cap_pulse = cap_event & ~cap_prev_q;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cap_prev_q <= '0;
         cap_done_q <= '0;
      end else begin
         cap_prev_q <= cap_event;
         // Flag follows the most recent capture, one cycle pulse
         cap_done_q <= cap_pulse;
      end
   end

   // Kill: a latched kill holds until cleared; a new kill wins over the clear
   logic kill_hold_q;
   logic kill_now;

   // The hold only forms while kill_latch is high; without it the pins follow kill
   assign kill_now = kill || kill_hold_q;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         kill_hold_q <= 1'b0;
         kill_active_q <= 1'b0;
      end else begin
         kill_hold_q <= kill_latch && (kill || (kill_hold_q && !kill_clear));
         kill_active_q <= kill_now;
      end
   end

   // Per-counter datapath and dead-band stage
   logic [`TCPQ_NUM_CH-1:0] pwm_raw;

   // Complementary leg only conducts while its counter is enabled, so a disabled
   // channel leaves both switches open
   function automatic logic tcpq_comp_leg(
      input logic en,
      input logic raw
   );
      return en && !raw;
   endfunction : tcpq_comp_leg

   genvar gi;
   generate
      for (gi = 0; gi < `TCPQ_NUM_CH; gi = gi + 1) begin : g_ch
         // Counter, capture and compare of one channel
         tcpq_channel u_chan (
            .mclk(mclk),
            .sys_rst(sys_rst),
            .tick(tick_q),
            .enable(cnt_enable[gi]),
            .reload_mode(cnt_reload[gi]),
            .period(cnt_period[gi]),
            .compare(cnt_compare[gi]),
            .cap_pulse(cap_pulse[gi]),
            .count_q(count_q[gi]),
            .cap_q(capture_q[gi]),
            .pwm_q(pwm_raw[gi]),
            .tc_q(period_match_q[gi]),
            .run_q(running_q[gi])
         );

         // Each edge of the raw PWM starts a dead interval with both legs off,
         // so the two switches of a half bridge never conduct together
         tcpq_db_state_t db_state_q;
         tcpq_db_state_t db_state_d;
         logic raw_prev_q;
         logic [`TCPQ_DB_W-1:0] db_cnt_q;
         logic [`TCPQ_DB_W-1:0] db_cnt_d;
         logic db_true_q;
         logic db_comp_q;
         logic db_true_d;
         logic db_comp_d;
         logic raw_edge;
         logic db_done;
         logic settle_comp;

         assign raw_edge = (pwm_raw[gi] != raw_prev_q);
         assign db_done = (db_cnt_q == `TCPQ_DB_RST);
         // Dead time is counted in divided ticks, so it scales with clk_div
         assign settle_comp = tcpq_comp_leg(cnt_enable[gi], pwm_raw[gi]);

         // With dead_time at zero both legs still rest off for one cycle

         always_comb begin
            db_state_d = db_state_q;
            db_cnt_d = db_cnt_q;
            db_true_d = db_true_q;
            db_comp_d = db_comp_q;
            if (raw_edge) begin
               db_cnt_d = dead_time[gi];
               db_true_d = 1'b0;
               db_comp_d = 1'b0;
               db_state_d = TCPQ_DB_WAIT;
            end else begin
               case (db_state_q)
                  TCPQ_DB_SETTLED: begin
                     db_true_d = pwm_raw[gi];
                     db_comp_d = settle_comp;
                  end
                  TCPQ_DB_WAIT: begin
                     if (db_done) begin
                        db_true_d = pwm_raw[gi];
                        db_comp_d = settle_comp;
                        db_state_d = TCPQ_DB_SETTLED;
                     end else if (tick_q) begin
                        db_cnt_d = db_cnt_q - `TCPQ_DB_STEP;
                     end
                  end
                  default: begin
                     db_state_d = TCPQ_DB_SETTLED;
                  end
               endcase
            end
         end

         always_ff @(posedge mclk) begin
            if (sys_rst) begin
               db_state_q <= TCPQ_DB_SETTLED;
               raw_prev_q <= 1'b0;
               db_cnt_q <= `TCPQ_DB_RST;
               db_true_q <= 1'b0;
               db_comp_q <= 1'b0;
            end else begin
               db_state_q <= db_state_d;
               raw_prev_q <= pwm_raw[gi];
               db_cnt_q <= db_cnt_d;
               db_true_q <= db_true_d;
               db_comp_q <= db_comp_d;
            end
         end

         // Kill bypasses the dead-band stage: only the pin flop sits in the path
         logic out_true_d;
         logic out_comp_d;

         assign out_true_d = kill_now ? kill_true_lvl[gi] : db_true_q;
         assign out_comp_d = kill_now ? kill_comp_lvl[gi] : db_comp_q;

         always_ff @(posedge mclk) begin
            if (sys_rst) begin
               pwm_true_q[gi] <= 1'b0;
               pwm_comp_q[gi] <= 1'b0;
            end else begin
               pwm_true_q[gi] <= out_true_d;
               pwm_comp_q[gi] <= out_comp_d;
            end
         end
      end
   endgenerate

endmodule : tcpq_top

// ### dv/tcpq_load.sv
// Stand-in for the power stage driven by the PWM pins
`timescale 1ns/1ps
module tcpq_load (
   // Clock
   input logic mclk,
   // Gate drives
   input logic [3:0] pwm_true_q,
   input logic [3:0] pwm_comp_q,
   // Cycles with both legs of a pair conducting
   output int shoot
);
   initial shoot = 0;
   // Both legs on at once would short the supply
   always @(posedge mclk) begin
      if (|(pwm_true_q & pwm_comp_q)) shoot <= shoot + 1;
   end
endmodule : tcpq_load

// ### dv/tcpq_top_sva.sv
// Port checker for the quad timer/counter/PWM unit
`timescale 1ns/1ps
module tcpq_top_sva (
   // Clock and reset
   input logic mclk,
   input logic sys_rst,
   // Inputs
   input logic [3:0] cnt_enable,
   input logic [3:0] cnt_reload,
   input logic [3:0][15:0] cnt_period,
   input logic [3:0][15:0] cnt_compare,
   input logic [3:0] cap_event,
   input logic kill,
   input logic [3:0] kill_true_lvl,
   input logic [3:0] kill_comp_lvl,
   // Outputs
   input logic [3:0] pwm_true_q,
   input logic [3:0] pwm_comp_q,
   input logic [3:0][15:0] count_q,
   input logic [3:0][15:0] capture_q,
   input logic [3:0] cap_done_q,
   input logic [3:0] running_q,
   input logic kill_active_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_count_step: assert property ($changed(count_q[0]) |->
      count_q[0] == $past(count_q[0]) + 16'h0001 || count_q[0] == 16'h0000) else $error("step");
   a_period_wrap: assert property ($changed(count_q[0]) &&
      $past(count_q[0]) == $past(cnt_period[0]) |-> count_q[0] == 16'h0000) else $error("wrap");
   a_oneshot_park: assert property (cnt_enable[1] && !cnt_reload[1] &&
      count_q[1] == cnt_period[1] ##1 cnt_enable[1] |-> $stable(count_q[1])) else $error("park");
   a_capture_load: assert property (cap_event[1] && !$past(cap_event[1]) |=>
      cap_done_q[1] && capture_q[1] == $past(count_q[1])) else $error("capture");
   a_pwm_raw: assert property (pwm_true_q[2] && !kill_active_q && cnt_enable[2] |->
      $past(count_q[2], 3) < $past(cnt_compare[2], 3)) else $error("duty");
   a_dead_band: assert property (!kill_active_q |->
      (pwm_true_q & pwm_comp_q) == 4'h0) else $error("overlap");
   a_kill_force: assert property (kill |=> kill_active_q &&
      pwm_true_q == $past(kill_true_lvl) && pwm_comp_q == $past(kill_comp_lvl)) else $error("kill");
   a_disable_zero: assert property (!cnt_enable[0] |=>
      count_q[0] == 16'h0000 && !running_q[0]) else $error("disable");
endmodule : tcpq_top_sva

bind tcpq_top tcpq_top_sva u_sva (.mclk, .sys_rst, .cnt_enable, .cnt_reload, .cnt_period,
   .cnt_compare, .cap_event, .kill, .kill_true_lvl, .kill_comp_lvl, .pwm_true_q, .pwm_comp_q,
   .count_q, .capture_q, .cap_done_q, .running_q, .kill_active_q);

// ### dv/tcpq_top_test.sv
// Self-checking bench for the quad timer/counter/PWM unit
`timescale 1ns/1ps
module tcpq_top_test;
   logic mclk = 0, sys_rst = 1, kill = 0, kill_latch = 0, kill_clear = 0;
   logic [15:0] clk_div = 16'h0000, snap;
   logic [3:0] cnt_enable = 4'h0, cnt_reload = 4'h0, cap_event = 4'h0;
   logic [3:0] kill_true_lvl = 4'hA, kill_comp_lvl = 4'h5;
   logic [3:0][15:0] cnt_period = '0, cnt_compare = '0;
   logic [3:0][7:0] dead_time = '0;
   logic [3:0] pwm_true_q, pwm_comp_q, cap_done_q, period_match_q, running_q;
   logic [3:0][15:0] count_q, capture_q;
   logic kill_active_q;
   int shoot, err_total = 0, checked = 0;
   tcpq_top i_dut (.mclk, .sys_rst, .clk_div, .cnt_enable, .cnt_reload, .cnt_period,
      .cnt_compare, .dead_time, .cap_event, .kill, .kill_latch, .kill_clear, .kill_true_lvl,
      .kill_comp_lvl, .pwm_true_q, .pwm_comp_q, .count_q, .capture_q, .cap_done_q,
      .period_match_q, .running_q, .kill_active_q);
   tcpq_load i_load (.mclk, .pwm_true_q, .pwm_comp_q, .shoot);
   always #5 mclk = ~mclk;
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask : cyc
   task wrap_up;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   task t_count;
      int i;
      cnt_period[0] = 16'h0003;
      cnt_period[1] = 16'h0002;
      cnt_reload = 4'h1;
      cnt_enable[1:0] = 2'h3;
      i = 0;
      while (count_q[0] !== 16'h0003 && i < 20) begin
         cyc(1);
         i++;
      end
      chk(count_q[0], 16'h0003);
      cyc(1);
      chk(count_q[0], 16'h0000);
      chk(16'(period_match_q[0]), 16'h0001);
      cyc(1);
      chk(16'(period_match_q[0]), 16'h0000);
      cyc(8);
      chk(count_q[1], 16'h0002);
      chk(16'(running_q[1]), 16'h0000);
      $display("count test done");
   endtask : t_count
   task t_capture;
      // Counter 1 is parked, so the captured value is its period
      cap_event[1] = 1'b1;
      cyc(1);
      chk(capture_q[1], 16'h0002);
      chk(16'(cap_done_q[1]), 16'h0001);
      cyc(3);
      chk(16'(cap_done_q[1]), 16'h0000);
      cap_event[1] = 1'b0;
      $display("capture test done");
   endtask : t_capture
   task t_pwm;
      cnt_period[3:2] = {16'h0009, 16'h0009};
      cnt_compare[2] = 16'hFFFF;
      dead_time[2] = 8'h03;
      cnt_reload[3:2] = 2'h3;
      cnt_enable[3:2] = 2'h3;
      cyc(30);
      chk(16'({pwm_true_q[3:2], pwm_comp_q[3:2]}), 16'h0006);
      cnt_compare[2] = 16'h0000;
      cyc(3);
      chk(16'({pwm_true_q[2], pwm_comp_q[2]}), 16'h0000);
      cyc(10);
      chk(16'({pwm_true_q[2], pwm_comp_q[2]}), 16'h0001);
      $display("pwm test done");
   endtask : t_pwm
   task t_div;
      cnt_period[3] = 16'hFFFF;
      clk_div = 16'h0003;
      cyc(8);
      snap = count_q[3];
      cyc(40);
      chk(count_q[3] - snap, 16'h000A);
      clk_div = 16'h0000;
      $display("divider test done");
   endtask : t_div
   task t_kill;
      kill = 1'b1;
      cyc(1);
      chk(16'({pwm_true_q, pwm_comp_q, 7'h00, kill_active_q}), 16'hA501);
      kill_latch = 1'b1;
      cyc(1);
      kill = 1'b0;
      cyc(3);
      chk(16'(kill_active_q), 16'h0001);
      kill_clear = 1'b1;
      cyc(2);
      kill_clear = 1'b0;
      chk(16'(kill_active_q), 16'h0000);
      // A kill that meets a clear in the same cycle still latches
      cyc(1);
      kill = 1'b1;
      kill_clear = 1'b1;
      cyc(1);
      kill = 1'b0;
      kill_clear = 1'b0;
      cyc(2);
      chk(16'(kill_active_q), 16'h0001);
      kill_clear = 1'b1;
      cyc(2);
      kill_clear = 1'b0;
      kill_latch = 1'b0;
      chk(16'(kill_active_q), 16'h0000);
      chk(16'({pwm_true_q, pwm_comp_q}), 16'h000F);
      $display("kill test done");
   endtask : t_kill
   task t_reset;
      // Reset in mid-run zeroes and stops every counter, then counting restarts
      sys_rst = 1'b1;
      cyc(2);
      chk(count_q[3], 16'h0000);
      chk(16'({running_q, pwm_true_q, pwm_comp_q}), 16'h0000);
      sys_rst = 1'b0;
      cyc(2);
      chk(count_q[0], 16'h0001);
      chk(16'(running_q), 16'h000F);
      $display("reset test done");
   endtask : t_reset
   initial begin
      cyc(4);
      sys_rst = 1'b0;
      t_count;
      t_capture;
      t_pwm;
      t_div;
      t_kill;
      t_reset;
      chk(16'(shoot), 16'h0000);
      wrap_up;
   end
   // Tests need about 130 cycles; allow about fifteen times that
   initial begin
      #20000;
      err_total++;
      wrap_up;
   end
endmodule : tcpq_top_test
